// ==== rtl/shutter_pkg.sv ====
/*
 * Constants shared by the substrate-clear shutter generator: register
 * indices, field positions and widths, reset values and bus responses.
 * Assumes a 32-bit AXI4-Lite register bus with one word per register,
 * the byte address of each register being four times its index.
 */
package shutter_pkg;

    // Register indices; byte address is index * 4.
    localparam logic [5:0] IDX_MODE = 6'h01;
    localparam logic [5:0] IDX_COUNT = 6'h0B;
    localparam logic [5:0] IDX_SHAPE_A = 6'h0E;
    localparam logic [5:0] IDX_SHAPE_B = 6'h0F;
    localparam logic [5:0] IDX_SHAPE_CFG = 6'h10;
    localparam logic [5:0] IDX_STATUS = 6'h11;

    // Mode word fields.
    localparam int SUPPRESS_BIT = 0;
    localparam int HP_MODE_BIT = 1;
    localparam logic [31:0] MODE_MASK = 32'h0000_0003;

    // Count word fields.
    localparam int COUNT_LSB = 0;
    localparam int COUNT_W = 11;
    localparam int ENABLE_BIT = 11;
    localparam int HP_LSB = 12;
    localparam int HP_W = 3;
    localparam logic [31:0] COUNT_MASK = 32'h0000_7FFF;

    // Shape words: first toggle low, second toggle high.
    localparam int TOG_W = 9;
    localparam int TOG1_LSB = 0;
    localparam int TOG2_LSB = 16;
    localparam logic [31:0] SHAPE_MASK = 32'h01FF_01FF;

    // Shape configuration word: selector and sensor-gate line.
    localparam int SHAPE_SEL_BIT = 0;
    localparam int GATE_LINE_LSB = 8;
    localparam int LINE_W = 7;
    localparam logic [31:0] SHAPE_CFG_MASK = 32'h0000_7F01;

    // Status word fields.
    localparam int STAT_ISSUED_LSB = 0;
    localparam int STAT_GATE_BIT = 16;
    localparam int STAT_SEG_LSB = 20;
    localparam int STAT_LINE_LSB = 24;

    // Values after reset.
    localparam logic [31:0] MODE_RESET = 32'h0000_0000;
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
    localparam logic [31:0] SHAPE_RESET = 32'h0000_0000;
    localparam logic [31:0] SHAPE_CFG_RESET = 32'h0000_0000;

    // Line-offset segments within a line: segment 0 plus seven extras.
    localparam int SEG_W = 3;
    localparam logic [SEG_W-1:0] SEG_LAST = 3'h7;
    localparam logic [LINE_W-1:0] LINE_LAST = 7'h7F;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== rtl/toggle_window.sv ====
/*
 * Compares a position counter with a pair of toggle positions and
 * reports whether the position lies in the high part of the pulse.
 * Assumes all three inputs belong to the caller's clock domain.
 */
`timescale 1ns/1ns
module toggle_window #(
    parameter int W = 9
) (
    input wire logic [W-1:0] pos_in,
    input wire logic [W-1:0] first_in,
    input wire logic [W-1:0] second_in,
    output logic inside_out
);

    // The pulse rises at the first toggle and falls at the second.
    assign inside_out = (pos_in >= first_in) && (pos_in < second_in);

endmodule

// ==== rtl/substrate_shutter_gen.sv ====
/*
 * Substrate-clear pulse generator for electronic exposure control,
 * with normal, suppression and high-precision shutter modes and an
 * AXI4-Lite register slave. Assumes frame and line sync arrive as
 * asynchronous pins and that everything else runs on ref_clk_in.
 */
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
// Overview of operation
// - at most one normal pulse per line
// - pulses per field equal 11-bit count
// - first pulse on line after gate line
// - suppress bit omits first pulse after gate
// - mode bit picks single or multiple pulses
// - zero extra field keeps plain normal operation
// - single mode adds pulse at position n
// - multiple mode adds n sequential extra pulses
// - enable bit low holds output inactive
// - two shapes of two 9-bit toggles
// - shape selector picks first or second pair
// - gate line is 7-bit index from frame
module substrate_shutter_gen #(
    parameter int ADDR_W = 8
) (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic [ADDR_W-1:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    output logic [1:0] bresp_out,
    output logic bvalid_out,
    input wire logic bready_in,
    input wire logic [ADDR_W-1:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out,
    output logic rvalid_out,
    input wire logic rready_in,
    input wire logic frame_sync_in,
    input wire logic line_sync_in,
    output logic substrate_clear_pulse_out
);

    logic [31:0] mode_reg;
    logic [31:0] count_reg;
    logic [31:0] shape_a_reg;
    logic [31:0] shape_b_reg;
    logic [31:0] shape_cfg_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    logic frame_meta_reg, frame_sync_reg, frame_prev_reg;
    logic line_meta_reg, line_sync_reg, line_prev_reg;
    logic [shutter_pkg::TOG_W-1:0] offset_reg;
    logic [shutter_pkg::SEG_W-1:0] seg_reg;
    logic [shutter_pkg::LINE_W-1:0] line_reg;
    logic [shutter_pkg::COUNT_W-1:0] issued_reg;
    logic gate_seen_reg;
    logic suppress_done_reg;
    logic line_active_reg;
    logic line_supp_reg;
    logic pulse_reg;

    // Field views of the control registers.
    logic suppress, hp_mode, out_enable, shape_sel, in_shape, seg_hit;
    logic [shutter_pkg::COUNT_W-1:0] pulse_count;
    logic [shutter_pkg::HP_W-1:0] hp_value;
    logic [shutter_pkg::LINE_W-1:0] gate_line;
    logic [shutter_pkg::TOG_W-1:0] tog1, tog2;
    logic frame_edge, line_edge, wr_fire, rd_fire;
    logic [5:0] wr_idx, rd_idx;
    logic [31:0] status_word;

    assign suppress = mode_reg[shutter_pkg::SUPPRESS_BIT];
    assign hp_mode = mode_reg[shutter_pkg::HP_MODE_BIT];
    assign pulse_count = count_reg[shutter_pkg::COUNT_LSB +:
        shutter_pkg::COUNT_W];
    assign out_enable = count_reg[shutter_pkg::ENABLE_BIT];
    assign hp_value = count_reg[shutter_pkg::HP_LSB +: shutter_pkg::HP_W];
    assign shape_sel = shape_cfg_reg[shutter_pkg::SHAPE_SEL_BIT];
    assign gate_line = shape_cfg_reg[shutter_pkg::GATE_LINE_LSB +:
        shutter_pkg::LINE_W];

    assign tog1 = shape_sel
        ? shape_b_reg[shutter_pkg::TOG1_LSB +: shutter_pkg::TOG_W]
        : shape_a_reg[shutter_pkg::TOG1_LSB +: shutter_pkg::TOG_W];
    assign tog2 = shape_sel
        ? shape_b_reg[shutter_pkg::TOG2_LSB +: shutter_pkg::TOG_W]
        : shape_a_reg[shutter_pkg::TOG2_LSB +: shutter_pkg::TOG_W];

    toggle_window #(
        .W(shutter_pkg::TOG_W)
    ) shape_cmp (
        .pos_in(offset_reg),
        .first_in(tog1),
        .second_in(tog2),
        .inside_out(in_shape)
    );

    // Applies byte strobes and clears bits that have no storage.
    function automatic logic [31:0] merge(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [3:0] strb,
        input logic [31:0] mask);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res & mask;
    endfunction

    // Write address and data are taken together, one write at a time.
    assign wr_fire = awvalid_in && wvalid_in && !bvalid_reg;
    assign awready_out = wr_fire;
    assign wready_out = wr_fire;
    assign wr_idx = awaddr_in[7:2];
    assign rd_fire = arvalid_in && !rvalid_reg;
    assign arready_out = !rvalid_reg;
    assign rd_idx = araddr_in[7:2];

    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            mode_reg <= shutter_pkg::MODE_RESET;
            count_reg <= shutter_pkg::COUNT_RESET;
            shape_a_reg <= shutter_pkg::SHAPE_RESET;
            shape_b_reg <= shutter_pkg::SHAPE_RESET;
            shape_cfg_reg <= shutter_pkg::SHAPE_CFG_RESET;
        end else if (wr_fire) begin
            case (wr_idx)
                shutter_pkg::IDX_MODE: begin
                    mode_reg <= merge(mode_reg, wdata_in, wstrb_in,
                        shutter_pkg::MODE_MASK);
                end
                shutter_pkg::IDX_COUNT: begin
                    count_reg <= merge(count_reg, wdata_in, wstrb_in,
                        shutter_pkg::COUNT_MASK);
                end
                shutter_pkg::IDX_SHAPE_A: begin
                    shape_a_reg <= merge(shape_a_reg, wdata_in, wstrb_in,
                        shutter_pkg::SHAPE_MASK);
                end
                shutter_pkg::IDX_SHAPE_B: begin
                    shape_b_reg <= merge(shape_b_reg, wdata_in, wstrb_in,
                        shutter_pkg::SHAPE_MASK);
                end
                shutter_pkg::IDX_SHAPE_CFG: begin
                    shape_cfg_reg <= merge(shape_cfg_reg, wdata_in,
                        wstrb_in, shutter_pkg::SHAPE_CFG_MASK);
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= shutter_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            case (wr_idx)
                shutter_pkg::IDX_MODE, shutter_pkg::IDX_COUNT,
                shutter_pkg::IDX_SHAPE_A, shutter_pkg::IDX_SHAPE_B,
                shutter_pkg::IDX_SHAPE_CFG: begin
                    bresp_reg <= shutter_pkg::RESP_OKAY;
                end
                default: begin
                    bresp_reg <= shutter_pkg::RESP_SLVERR;
                end
            endcase
        end else if (bready_in) begin
            bvalid_reg <= 1'b0;
        end
    end

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[shutter_pkg::STAT_ISSUED_LSB +:
            shutter_pkg::COUNT_W] = issued_reg;
        status_word[shutter_pkg::STAT_GATE_BIT] = gate_seen_reg;
        status_word[shutter_pkg::STAT_SEG_LSB +: shutter_pkg::SEG_W] =
            seg_reg;
        status_word[shutter_pkg::STAT_LINE_LSB +: shutter_pkg::LINE_W] =
            line_reg;
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            rvalid_reg <= 1'b0;
            rresp_reg <= shutter_pkg::RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end else if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= shutter_pkg::RESP_OKAY;
            case (rd_idx)
                shutter_pkg::IDX_MODE: rdata_reg <= mode_reg;
                shutter_pkg::IDX_COUNT: rdata_reg <= count_reg;
                shutter_pkg::IDX_SHAPE_A: rdata_reg <= shape_a_reg;
                shutter_pkg::IDX_SHAPE_B: rdata_reg <= shape_b_reg;
                shutter_pkg::IDX_SHAPE_CFG: rdata_reg <= shape_cfg_reg;
                shutter_pkg::IDX_STATUS: rdata_reg <= status_word;
                default: begin
                    rdata_reg <= 32'h0000_0000;
                    rresp_reg <= shutter_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rready_in) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign bvalid_out = bvalid_reg;
    assign bresp_out = bresp_reg;
    assign rvalid_out = rvalid_reg;
    assign rresp_out = rresp_reg;
    assign rdata_out = rdata_reg;

    // Sync pins are asynchronous; only the second and third stages are looked at.
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            frame_meta_reg <= 1'b0;
            frame_sync_reg <= 1'b0;
            frame_prev_reg <= 1'b0;
            line_meta_reg <= 1'b0;
            line_sync_reg <= 1'b0;
            line_prev_reg <= 1'b0;
        end else begin
            frame_meta_reg <= frame_sync_in;
            frame_sync_reg <= frame_meta_reg;
            frame_prev_reg <= frame_sync_reg;
            line_meta_reg <= line_sync_in;
            line_sync_reg <= line_meta_reg;
            line_prev_reg <= line_sync_reg;
        end
    end

    assign frame_edge = frame_sync_reg && !frame_prev_reg;
    assign line_edge = line_sync_reg && !line_prev_reg;

    // Offset counter wraps each 512 clocks; each wrap opens a segment.
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in || line_edge || frame_edge) begin
            offset_reg <= '0;
            seg_reg <= '0;
        end else begin
            // hold after last segment
            // A wrap inside the last segment would open a ninth pulse slot
            // in long lines, so the counter parks at its top value instead.
            if (!(&offset_reg) || seg_reg != shutter_pkg::SEG_LAST) begin
                offset_reg <= offset_reg + 1'b1;
            end
            if (&offset_reg && seg_reg != shutter_pkg::SEG_LAST) begin
                seg_reg <= seg_reg + 1'b1;
            end
        end
    end

    // Line bookkeeping; a frame edge also starts line zero.
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            line_reg <= '0;
            issued_reg <= '0;
            gate_seen_reg <= 1'b0;
            suppress_done_reg <= 1'b0;
            line_active_reg <= 1'b0;
            line_supp_reg <= 1'b0;
        end else if (frame_edge) begin
            line_reg <= '0;
            issued_reg <= '0;
            gate_seen_reg <= 1'b0;
            suppress_done_reg <= 1'b0;
            line_active_reg <= 1'b0;
            line_supp_reg <= 1'b0;
        end else if (line_edge) begin
            if (line_reg != shutter_pkg::LINE_LAST) begin
                line_reg <= line_reg + 1'b1;
            end
            if (line_reg == gate_line) begin
                gate_seen_reg <= 1'b1;
            end
            if ((gate_seen_reg || line_reg == gate_line) &&
                issued_reg < pulse_count) begin
                line_active_reg <= 1'b1;
                issued_reg <= issued_reg + 1'b1;
                // first slot is omitted yet counted
                line_supp_reg <= suppress && !suppress_done_reg;
                suppress_done_reg <= 1'b1;
            end else begin
                line_active_reg <= 1'b0;
                line_supp_reg <= 1'b0;
            end
        end
    end

    // multiple mode hits segments 1 to n
    always_comb begin
        if (seg_reg == '0) begin
            seg_hit = 1'b1;
        end else if (hp_value == '0) begin
            seg_hit = 1'b0;
        end else if (hp_mode) begin
            seg_hit = seg_reg <= hp_value;
        end else begin
            seg_hit = seg_reg == hp_value;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            pulse_reg <= 1'b0;
        end else begin
            pulse_reg <= out_enable && line_active_reg && !line_supp_reg &&
                seg_hit && in_shape;
        end
    end

    assign substrate_clear_pulse_out = pulse_reg;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    sequence field_start;
        frame_edge;
    endsequence

    sequence field_cleared;
        issued_reg == '0 && !gate_seen_reg && !suppress_done_reg;
    endsequence

    output_gate_a: assert property (
        !out_enable |=> !substrate_clear_pulse_out)
        else $error("pulse seen while output disabled");
    count_limit_a: assert property (
        line_edge && !frame_edge && issued_reg >= pulse_count
        |=> !line_active_reg && $stable(issued_reg))
        else $error("pulse line granted beyond field count");
    gate_first_a: assert property (
        !gate_seen_reg |-> !line_active_reg)
        else $error("pulse line before the gate line");
    one_per_line_a: assert property (
        $changed(issued_reg) |-> $past(line_edge || frame_edge))
        else $error("count advanced inside a line");
    suppress_first_a: assert property (
        line_supp_reg |=> !substrate_clear_pulse_out)
        else $error("suppressed pulse emitted");
    single_pos_a: assert property (
        !hp_mode && seg_reg != '0 && seg_reg != hp_value
        |=> !substrate_clear_pulse_out)
        else $error("single mode pulse at wrong position");
    multi_count_a: assert property (
        hp_mode && seg_reg > hp_value |=> !substrate_clear_pulse_out)
        else $error("too many extra pulses");
    last_seg_hold_a: assert property (
        seg_reg == shutter_pkg::SEG_LAST && &offset_reg && !line_edge &&
        !frame_edge |=> &offset_reg && !substrate_clear_pulse_out)
        else $error("pulse after the last segment");
    shape_window_a: assert property (
        substrate_clear_pulse_out |->
        $past(offset_reg) >= $past(tog1) && $past(offset_reg) < $past(tog2))
        else $error("pulse outside selected toggle pair");
    field_clear_a: assert property (
        field_start |=> field_cleared)
        else $error("field state not cleared at frame sync");

endmodule

// ==== sim/shutter_sensor_model.sv ====
/*
 * Stand-in for the sensor side: drives frame and line sync and counts
 * the substrate-clear pulses and their high cycles in each line.
 * Assumes one clock shared with the generator under test.
 */
`timescale 1ns/1ns
module shutter_sensor_model (
    input wire logic clk_in,
    input wire logic pulse_in,
    output logic frame_sync_out,
    output logic line_sync_out
);
    int line_no = 8;
    int edges [8];
    int high [8];
    logic pulse_d = 1'b0;

    initial begin
        frame_sync_out = 1'b0;
        line_sync_out = 1'b0;
    end

    always @(posedge clk_in) begin
        pulse_d <= pulse_in;
        if (line_no < 8 && pulse_in === 1'b1) begin
            high[line_no] <= high[line_no] + 1;
            if (pulse_d !== 1'b1) begin
                edges[line_no] <= edges[line_no] + 1;
            end
        end
    end

    // A line is booked only once its sync is low again, so a pulse cut
    // short by the sync delay is never counted in the new line.
    task automatic run_frame(input int len, input int lines);
        for (int i = 0; i < 8; i++) begin
            edges[i] = 0;
            high[i] = 0;
        end
        for (int l = 0; l < lines; l++) begin
            @(posedge clk_in);
            frame_sync_out <= (l == 0);
            line_sync_out <= 1'b1;
            repeat (6) @(posedge clk_in);
            frame_sync_out <= 1'b0;
            line_sync_out <= 1'b0;
            line_no <= l;
            repeat (len - 7) @(posedge clk_in);
        end
        @(posedge clk_in);
        line_no <= 8;
    endtask
endmodule

// ==== sim/ccd_substrate_shutter_pulse_gen_test.sv ====
/*
 * Self-checking bench for the substrate-clear pulse generator.
 * Assumes the sensor model drives the sync pins and counts pulses.
 */
`timescale 1ns/1ns
module ccd_substrate_shutter_pulse_gen_test;
    typedef struct packed {
        logic [1:0] mode;
        logic [14:0] count;
        logic [14:0] cfg;
        logic [15:0] len;
        logic [3:0] lines;
        logic [23:0] want;
    } row_t;
    localparam logic [1:0] OKAY = shutter_pkg::RESP_OKAY;
    localparam logic [1:0] SLVERR = shutter_pkg::RESP_SLVERR;
    logic ref_clk_in, rst_b_in, aw_valid, w_valid, b_ready;
    logic ar_valid, r_ready, aw_ready, w_ready, b_valid, ar_ready, r_valid;
    logic [7:0] aw_addr, ar_addr;
    logic [31:0] w_data, r_data;
    logic [1:0] b_resp, r_resp;
    logic frame_sync, line_sync, pulse;
    int fails = 0;
    int cmp_count = 0;
    logic [5:0] regs [5] = '{shutter_pkg::IDX_MODE, shutter_pkg::IDX_COUNT,
        shutter_pkg::IDX_SHAPE_A, shutter_pkg::IDX_SHAPE_B,
        shutter_pkg::IDX_SHAPE_CFG};
    logic [31:0] masks [5] = '{shutter_pkg::MODE_MASK, shutter_pkg::COUNT_MASK,
        shutter_pkg::SHAPE_MASK, shutter_pkg::SHAPE_MASK,
        shutter_pkg::SHAPE_CFG_MASK};
    // Pulses expected per line, line 0 in the lowest nibble.
    row_t rows [12] = '{
        '{2'h0, 15'h0802, 15'h0000, 16'h0258, 4'h6, 24'h000110},
        '{2'h0, 15'h0802, 15'h0200, 16'h0258, 4'h6, 24'h011000},
        '{2'h1, 15'h0802, 15'h0000, 16'h0258, 4'h6, 24'h000100},
        '{2'h0, 15'h0003, 15'h0000, 16'h0258, 4'h6, 24'h000000},
        '{2'h0, 15'h0800, 15'h0000, 16'h0258, 4'h6, 24'h000000},
        '{2'h0, 15'h1801, 15'h0000, 16'h0258, 4'h3, 24'h000020},
        '{2'h0, 15'h3801, 15'h0000, 16'h044C, 4'h3, 24'h000010},
        '{2'h0, 15'h3801, 15'h0000, 16'h0866, 4'h3, 24'h000020},
        '{2'h2, 15'h3801, 15'h0000, 16'h0866, 4'h3, 24'h000040},
        '{2'h2, 15'h0801, 15'h0000, 16'h0866, 4'h3, 24'h000010},
        '{2'h2, 15'h7801, 15'h0000, 16'h1068, 4'h3, 24'h000080},
        '{2'h0, 15'h0802, 15'h0001, 16'h0258, 4'h6, 24'h000110}
    };

    substrate_shutter_gen dut_u (
        .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
        .awaddr_in(aw_addr), .awvalid_in(aw_valid), .awready_out(aw_ready),
        .wdata_in(w_data), .wstrb_in(4'hF), .wvalid_in(w_valid),
        .wready_out(w_ready), .bresp_out(b_resp), .bvalid_out(b_valid),
        .bready_in(b_ready), .araddr_in(ar_addr), .arvalid_in(ar_valid),
        .arready_out(ar_ready), .rdata_out(r_data), .rresp_out(r_resp),
        .rvalid_out(r_valid), .rready_in(r_ready),
        .frame_sync_in(frame_sync), .line_sync_in(line_sync),
        .substrate_clear_pulse_out(pulse)
    );

    shutter_sensor_model model_u (
        .clk_in(ref_clk_in), .pulse_in(pulse),
        .frame_sync_out(frame_sync), .line_sync_out(line_sync)
    );

    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    task automatic finish_test();
        if (fails == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] want);
        cmp_count++;
        if (got !== want) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
        end
    endtask

    task automatic give_up(input int n);
        if (n >= 200) begin
            fails++;
            $display("CHECK FAILED at %0t: bus answer missing", $time);
            finish_test();
        end
    endtask

    task automatic bus_write(input logic [5:0] idx, input logic [31:0] d,
            input logic [1:0] er);
        int n = 0;
        aw_addr <= {idx, 2'h0};
        w_data <= d;
        aw_valid <= 1'b1;
        w_valid <= 1'b1;
        do @(posedge ref_clk_in); while ((aw_ready & w_ready) !== 1'b1 &&
            ++n < 200);
        give_up(n);
        aw_valid <= 1'b0;
        w_valid <= 1'b0;
        b_ready <= 1'b1;
        n = 0;
        do @(posedge ref_clk_in); while (b_valid !== 1'b1 && ++n < 200);
        give_up(n);
        b_ready <= 1'b0;
        check(b_resp, er);
    endtask

    task automatic bus_read(input logic [5:0] idx, input logic [31:0] mask,
            input logic [31:0] want, input logic [1:0] er);
        int n = 0;
        ar_addr <= {idx, 2'h0};
        ar_valid <= 1'b1;
        do @(posedge ref_clk_in); while (ar_ready !== 1'b1 && ++n < 200);
        give_up(n);
        ar_valid <= 1'b0;
        r_ready <= 1'b1;
        n = 0;
        do @(posedge ref_clk_in); while (r_valid !== 1'b1 && ++n < 200);
        give_up(n);
        r_ready <= 1'b0;
        check(r_data & mask, want);
        check(r_resp, er);
    endtask

    initial begin
        int want_n;
        int w;
        rst_b_in = 1'b0;
        aw_valid = 1'b0;
        w_valid = 1'b0;
        b_ready = 1'b0;
        ar_valid = 1'b0;
        r_ready = 1'b0;
        aw_addr = 8'h00;
        ar_addr = 8'h00;
        w_data = 32'h00000000;
        repeat (5) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        foreach (regs[i]) begin
            bus_read(regs[i], 32'hFFFFFFFF, 32'h00000000, OKAY);
        end
        bus_read(shutter_pkg::IDX_STATUS, 32'h7FF, 32'h0, OKAY);
        foreach (regs[i]) begin
            bus_write(regs[i], 32'hFFFFFFFF, OKAY);
            bus_read(regs[i], 32'hFFFFFFFF, masks[i], OKAY);
        end
        // Unmapped and read-only places answer with an error.
        bus_write(6'h3F, 32'h0000FFFF, SLVERR);
        bus_read(6'h3F, 32'hFFFFFFFF, 32'h00000000, SLVERR);
        bus_write(shutter_pkg::IDX_STATUS, 32'h00000000, SLVERR);
        bus_write(shutter_pkg::IDX_SHAPE_A, 32'h0014000A, OKAY);
        bus_write(shutter_pkg::IDX_SHAPE_B, 32'h002D001E, OKAY);
        foreach (rows[r]) begin
            bus_write(shutter_pkg::IDX_MODE, 32'(rows[r].mode), OKAY);
            bus_write(shutter_pkg::IDX_COUNT, 32'(rows[r].count), OKAY);
            bus_write(shutter_pkg::IDX_SHAPE_CFG, 32'(rows[r].cfg), OKAY);
            model_u.run_frame(rows[r].len, rows[r].lines);
            w = rows[r].cfg[0] ? 15 : 10;
            for (int l = 0; l < rows[r].lines; l++) begin
                want_n = rows[r].want[4*l +: 4];
                check(model_u.edges[l], want_n);
                check(model_u.high[l], want_n * w);
            end
        end
        bus_read(shutter_pkg::IDX_STATUS, 32'h7FF, 32'h2, OKAY);
        model_u.run_frame(600, 1);
        bus_read(shutter_pkg::IDX_STATUS, 32'h7FF, 32'h0, OKAY);
        // A second reset in mid-run must bring the count word back.
        rst_b_in <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        bus_read(shutter_pkg::IDX_COUNT, 32'hFFFFFFFF,
            shutter_pkg::COUNT_RESET, OKAY);
        finish_test();
    end
endmodule
